// ---- include/adccfg_pkg.sv ----
// Package for the ADC mode configuration port: register map and field layout
package adccfg_pkg;
    // ======================================================================
    // Register addresses (7-bit)
    localparam logic [6:0] ADDR_SOFT_RESET_CONTROL  = 7'h00;
    localparam logic [6:0] ADDR_POWER_DOWN_CONTROL  = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT_CLOCK_TIMING = 7'h02;
    // ======================================================================
    // Field positions
    localparam int SOFT_RESET_BIT   = 7;
    localparam int PD_SLEEP_BIT     = 3;
    localparam int PD_NAP_BIT       = 2;
    localparam int TM_INVERT_BIT    = 3;
    localparam int TM_PHASE_HI      = 2;
    localparam int TM_PHASE_LO      = 1;
    localparam int TM_DCS_BIT       = 0;
    localparam logic [7:0] USED_MASK = 8'h0F;
    // ======================================================================
    // Reset values and frame layout
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam int         WORD_BITS       = 16;
    localparam logic [4:0] WORD_BITS_CNT   = 5'h10;
    localparam logic [4:0] DATA_START_CNT  = 5'h08;
    localparam logic [1:0] DRIVE_FULL      = 2'h0;
    localparam logic [1:0] DRIVE_HALF      = 2'h1;
    localparam logic [1:0] DRIVE_FROM_REG  = 2'h2;
    // ======================================================================
    // Synchroniser reset levels: an idle serial bus
    localparam logic       SYNC_IDLE_SEL   = 1'b0;
    localparam logic       SYNC_IDLE_CS_B  = 1'b1;
    localparam logic       SYNC_IDLE_SCK   = 1'b0;
    localparam logic       SYNC_IDLE_SDI   = 1'b0;
endpackage : adccfg_pkg

// ---- rtl/adccfg_port.sv ----
// ADC mode configuration port: parallel straps or serial register access
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Two-flop synchroniser for one asynchronous pin
module adccfg_sync2 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_level
);
    logic stage_a;
    logic next_stage_a;
    logic next_level;

    always_comb begin
        next_stage_a = i_pin;
        next_level   = stage_a;
    end

    // Only the second stage leaves; the first may be metastable
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            stage_a <= RESET_LEVEL;
            o_level <= RESET_LEVEL;
        end else begin
            stage_a <= next_stage_a;
            o_level <= next_level;
        end
    end

endmodule : adccfg_sync2

module adccfg_port
    import adccfg_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_interface_select,
    input  wire logic       i_cs_b,
    input  wire logic       i_sck,
    input  wire logic       i_sdi,
    output logic            o_sdo,
    output logic            o_sdo_oe,
    output logic            o_sleep,
    output logic            o_nap,
    output logic            o_duty_cycle_stabilizer,
    output logic            o_out_clock_invert,
    output logic [1:0]      o_out_clock_phase,
    output logic [1:0]      o_drive_select
);
    import adccfg_pkg::*;

    // ======================================================================
    // Pin synchronisers: two stages before any logic reads a pin
    // Both stages reset to an idle bus, so no false frame or edge follows
    logic       sel_s;
    logic       cs_b_s;
    logic       sck_s;
    logic       sdi_s;
    logic       sck_prev;
    logic       next_sck_prev;

    adccfg_sync2 #(
        .RESET_LEVEL (SYNC_IDLE_SEL)
    ) i_sync_select (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_pin       (i_interface_select),
        .o_level     (sel_s)
    );

    adccfg_sync2 #(
        .RESET_LEVEL (SYNC_IDLE_CS_B)
    ) i_sync_cs_b (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_pin       (i_cs_b),
        .o_level     (cs_b_s)
    );

    adccfg_sync2 #(
        .RESET_LEVEL (SYNC_IDLE_SCK)
    ) i_sync_sck (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_pin       (i_sck),
        .o_level     (sck_s)
    );

    adccfg_sync2 #(
        .RESET_LEVEL (SYNC_IDLE_SDI)
    ) i_sync_sdi (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_pin       (i_sdi),
        .o_level     (sdi_s)
    );

    always_comb begin
        next_sck_prev = sck_s;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sck_prev <= SYNC_IDLE_SCK;
        end else begin
            sck_prev <= next_sck_prev;
        end
    end

    logic serial_mode;
    logic active;
    logic sck_rise;
    logic sck_fall;

    assign serial_mode = !sel_s;
    assign active      = serial_mode && !cs_b_s;
    assign sck_rise    = active && sck_s && !sck_prev;
    assign sck_fall    = active && !sck_s && sck_prev;

    // ======================================================================
    // Serial frame engine
    logic [4:0]  bit_cnt;
    logic [14:0] shift_in;
    logic [7:0]  rd_shift;
    logic        sdo_low;
    logic [7:0]  pwr_reg;
    logic [7:0]  tim_reg;
    logic        rd_cmd;

    logic [4:0]  next_bit_cnt;
    logic [14:0] next_shift_in;
    logic [7:0]  next_rd_shift;
    logic        next_sdo_low;
    logic [7:0]  next_pwr_reg;
    logic [7:0]  next_tim_reg;
    logic        next_rd_cmd;

    logic        rd_flag;
    logic [6:0]  addr_now;
    logic [7:0]  data_now;
    logic [7:0]  rd_value;

    // The flag's place in the shifter moves each bit, so hold a copy
    assign rd_flag  = rd_cmd;
    assign addr_now = {shift_in[5:0], sdi_s};
    assign data_now = {shift_in[6:0], sdi_s};

    always_comb begin
        case (addr_now)
            ADDR_POWER_DOWN_CONTROL:  rd_value = pwr_reg & USED_MASK;
            ADDR_OUTPUT_CLOCK_TIMING: rd_value = tim_reg & USED_MASK;
            default:                  rd_value = REG_RESET_VALUE;
        endcase
    end

    always_comb begin
        next_bit_cnt  = bit_cnt;
        next_shift_in = shift_in;
        next_rd_shift = rd_shift;
        next_sdo_low  = sdo_low;
        next_pwr_reg  = pwr_reg;
        next_tim_reg  = tim_reg;
        next_rd_cmd   = rd_cmd;
        if (!active) begin
            next_bit_cnt = 5'h00;
            next_sdo_low = 1'b0;
            next_rd_cmd  = 1'b0;
        end else begin
            if (sck_rise && bit_cnt < WORD_BITS_CNT) begin
                next_bit_cnt  = bit_cnt + 5'h01;
                next_shift_in = {shift_in[13:0], sdi_s};
                if (bit_cnt == 5'h00) begin
                    next_rd_cmd = sdi_s;
                end
                // Address complete after eighth bit: latch readback
                if (bit_cnt == DATA_START_CNT - 5'h01) begin
                    next_rd_shift = rd_value;
                end
                if (bit_cnt == WORD_BITS_CNT - 5'h01 && !rd_flag) begin
                    // Word complete: write the addressed register
                    case (shift_in[13:7])
                        ADDR_SOFT_RESET_CONTROL: begin
                            if (data_now[SOFT_RESET_BIT]) begin
                                next_pwr_reg = REG_RESET_VALUE;
                                next_tim_reg = REG_RESET_VALUE;
                            end
                        end
                        ADDR_POWER_DOWN_CONTROL:
                            next_pwr_reg = data_now & USED_MASK;
                        ADDR_OUTPUT_CLOCK_TIMING:
                            next_tim_reg = data_now & USED_MASK;
                        default: ;
                    endcase
                end
            end
            // Readback bits change on falling edges, MSB first
            if (sck_fall && rd_flag && bit_cnt >= DATA_START_CNT
                && bit_cnt < WORD_BITS_CNT) begin
                next_sdo_low  = !rd_shift[7];
                next_rd_shift = {rd_shift[6:0], 1'b0};
            end
            if (sck_fall && bit_cnt >= WORD_BITS_CNT) begin
                next_sdo_low = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            bit_cnt  <= 5'h00;
            shift_in <= 15'h0000;
            rd_shift <= 8'h00;
            sdo_low  <= 1'b0;
            pwr_reg  <= REG_RESET_VALUE;
            tim_reg  <= REG_RESET_VALUE;
            rd_cmd   <= 1'b0;
        end else begin
            bit_cnt  <= next_bit_cnt;
            shift_in <= next_shift_in;
            rd_shift <= next_rd_shift;
            sdo_low  <= next_sdo_low;
            pwr_reg  <= next_pwr_reg;
            tim_reg  <= next_tim_reg;
            rd_cmd   <= next_rd_cmd;
        end
    end

    // ======================================================================
    // Mode outputs; parallel mode reads the synchronised pins directly
    logic       next_sleep;
    logic       next_nap;
    logic       next_dcs;
    logic       next_inv;
    logic [1:0] next_phase;
    logic [1:0] next_drive;

    always_comb begin
        if (!serial_mode) begin
            next_dcs   = cs_b_s;
            next_sleep = sck_s;
            next_nap   = 1'b0;
            next_drive = sdi_s ? DRIVE_HALF : DRIVE_FULL;
            next_inv   = 1'b0;
            next_phase = 2'h0;
        end else begin
            next_dcs   = tim_reg[TM_DCS_BIT];
            next_sleep = pwr_reg[PD_SLEEP_BIT];
            next_nap   = pwr_reg[PD_NAP_BIT];
            // Drive current lives in a register outside this block
            next_drive = DRIVE_FROM_REG;
            next_inv   = tim_reg[TM_INVERT_BIT];
            next_phase = tim_reg[TM_PHASE_HI:TM_PHASE_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_sleep                 <= 1'b0;
            o_nap                   <= 1'b0;
            o_duty_cycle_stabilizer <= 1'b0;
            o_out_clock_invert      <= 1'b0;
            o_out_clock_phase       <= 2'h0;
            o_drive_select          <= DRIVE_FULL;
        end else begin
            o_sleep                 <= next_sleep;
            o_nap                   <= next_nap;
            o_duty_cycle_stabilizer <= next_dcs;
            o_out_clock_invert      <= next_inv;
            o_out_clock_phase       <= next_phase;
            o_drive_select          <= next_drive;
        end
    end

    // ======================================================================
    // Open drain: output level is always low, enable pulls the line
    assign o_sdo    = 1'b0;
    assign o_sdo_oe = sdo_low && active;

endmodule : adccfg_port

`default_nettype wire

// ---- tb/adccfg_port_properties.sv ----
// Checker for the ADC mode configuration port
`timescale 1ns/1ps
`default_nettype none
module adccfg_port_properties
    import adccfg_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_interface_select,
    input wire logic       i_cs_b,
    input wire logic       i_sck,
    input wire logic       i_sdi,
    input wire logic       o_sdo,
    input wire logic       o_sdo_oe,
    input wire logic       o_sleep,
    input wire logic       o_nap,
    input wire logic       o_duty_cycle_stabilizer,
    input wire logic       o_out_clock_invert,
    input wire logic [1:0] o_out_clock_phase,
    input wire logic [1:0] o_drive_select
);
    // ======================================================================
    // Pin level checks, allowing for the input synchronisers
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_sdo_pulls_low: assert property (o_sdo == 1'b0)
        else $error("data out driven high");
    a_par_stabilizer: assert property (
        (i_interface_select && $stable(i_cs_b))[*6] |->
        o_duty_cycle_stabilizer == i_cs_b) else $error("stabilizer level");
    a_par_sleep: assert property (
        (i_interface_select && $stable(i_sck))[*6] |-> o_sleep == i_sck)
        else $error("sleep level");
    a_par_drive: assert property (
        (i_interface_select && $stable(i_sdi))[*6] |->
        o_drive_select == {1'b0, i_sdi}) else $error("drive select");
    a_par_quiet: assert property (
        i_interface_select[*6] |-> !o_nap && !o_out_clock_invert &&
        o_out_clock_phase == 2'h0) else $error("serial-only modes active");
    a_serial_drive: assert property (
        (!i_interface_select)[*6] |-> o_drive_select == DRIVE_FROM_REG)
        else $error("serial drive select");
    a_idle_no_pull: assert property (i_cs_b[*4] |-> !o_sdo_oe)
        else $error("data out pulled outside frame");
    a_idle_hold: assert property (
        (!i_interface_select && i_cs_b)[*6] |-> $stable(o_sleep) &&
        $stable(o_nap) && $stable(o_out_clock_phase) &&
        $stable(o_duty_cycle_stabilizer)) else $error("mode change idle");
endmodule : adccfg_port_properties
bind adccfg_port adccfg_port_properties i_props (.i_clk, .i_rst_b,
    .i_interface_select, .i_cs_b, .i_sck, .i_sdi, .o_sdo, .o_sdo_oe,
    .o_sleep, .o_nap, .o_duty_cycle_stabilizer, .o_out_clock_invert,
    .o_out_clock_phase, .o_drive_select);
`default_nettype wire

// ---- tb/adccfg_host_model.sv ----
// Host model: serial words on a 160 ns clock, or static parallel levels
`timescale 1ns/1ps
`default_nettype none
module adccfg_host_model (
    input  wire logic i_clk,
    input  wire logic i_sdo_line,
    output logic      o_cs_b,
    output logic      o_sck,
    output logic      o_sdi
);
    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end
    // ======================================================================
    // One framed word, MSB first, with optional surplus rising edges
    task automatic xfer(input logic [15:0] w, input int extra,
                        output logic [7:0] rd);
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        for (int k = 15; k >= -extra; k--) begin
            o_sdi <= (k >= 0) ? w[k] : 1'b1;
            repeat (20) @(posedge i_clk);
            o_sck <= 1'b1;
            if (k >= 0 && k < 8) rd = {rd[6:0], i_sdo_line};
            repeat (20) @(posedge i_clk);
            o_sck <= 1'b0;
        end
        repeat (20) @(posedge i_clk);
        o_cs_b <= 1'b1;
        o_sdi <= ~o_sdi;
        repeat (8) @(posedge i_clk);
    endtask : xfer
    task automatic levels(input logic [2:0] l);
        @(posedge i_clk);
        {o_cs_b, o_sck, o_sdi} <= l;
    endtask : levels
endmodule : adccfg_host_model
`default_nettype wire

// ---- tb/tb_adccfg_port.sv ----
// Self-checking bench for the ADC mode configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_adccfg_port;
    import adccfg_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       sel = 1'b0;
    logic       cs_b, sck, sdi, sdo, sdo_oe, sleep, nap, duty_cycle_stabilizer, inv;
    logic [1:0] phase, drive;
    logic [7:0] p, t, r;
    logic [31:0] v;
    int         failures = 0;
    int         n_tests = 0;
    int         seed = 32'hb821;
    wire        sdo_line = sdo_oe ? sdo : 1'b1;
    always #2 clk = ~clk;
    adccfg_port i_adccfg_port (.i_clk(clk), .i_rst_b(rst_b),
        .i_interface_select(sel), .i_cs_b(cs_b), .i_sck(sck), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sleep(sleep), .o_nap(nap),
        .o_duty_cycle_stabilizer(duty_cycle_stabilizer), .o_out_clock_invert(inv),
        .o_out_clock_phase(phase), .o_drive_select(drive));
    adccfg_host_model i_adccfg_host_model (.i_clk(clk),
        .i_sdo_line(sdo_line), .o_cs_b(cs_b), .o_sck(sck), .o_sdi(sdi));
    // ======================================================================
    // Checking helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    function automatic logic [7:0] mode_exp(input logic [7:0] pd, tm);
        return {2'b00, pd[3], pd[2], tm[3], tm[2:1], tm[0]};
    endfunction : mode_exp
    task automatic wr(input logic [6:0] a, input logic [7:0] d, int x);
        i_adccfg_host_model.xfer({1'b0, a, d}, x, r);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        i_adccfg_host_model.xfer({1'b1, a, v[31:24]}, 0, r);
        check(r, exp);
    endtask : rdchk
    task automatic outs;
        check({2'b00, sleep, nap, inv, phase, duty_cycle_stabilizer}, mode_exp(p, t));
        check({6'h0, drive}, {6'h0, DRIVE_FROM_REG});
    endtask : outs
    // ======================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        wr(ADDR_SOFT_RESET_CONTROL, 8'h80, 0);
        p = 8'h00;
        t = 8'h00;
        for (int n = 0; n < 6; n++) begin
            v = $random(seed);
            p = {v[7:2], 2'b00};
            t = v[15:8] | {7'h0, |v[10:9]};
            wr(ADDR_POWER_DOWN_CONTROL, p, int'(v[17:16]));
            wr(ADDR_OUTPUT_CLOCK_TIMING, t, int'(v[19:18]));
            wr(7'h03 + {4'h0, v[22:20]}, 8'hFF, 0);
            rdchk(ADDR_POWER_DOWN_CONTROL, p & 8'h0F);
            rdchk(ADDR_OUTPUT_CLOCK_TIMING, t & 8'h0F);
            rdchk(ADDR_SOFT_RESET_CONTROL, 8'h00);
            outs();
        end
        wr(ADDR_SOFT_RESET_CONTROL, 8'h80, 0);
        p = 8'h00;
        t = 8'h00;
        outs();
        rdchk(ADDR_OUTPUT_CLOCK_TIMING, 8'h00);
        sel <= 1'b1;
        for (int l = 0; l < 8; l++) begin
            i_adccfg_host_model.levels(3'(l));
            repeat (8) @(posedge clk);
            check({2'b00, sleep, nap, inv, phase, duty_cycle_stabilizer},
                  {2'b00, l[1], 4'h0, l[2]});
            check({6'h0, drive}, {7'h0, l[0]});
        end
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : tb_adccfg_port
`default_nettype wire
